/* File: dcfifo_pkg.sv */
package dcfifo_pkg;
  localparam int DATA_W = 18;
  localparam int DEPTH_DEFAULT = 32768;
  localparam int OFS_PARALLEL_DEFAULT = 127;
  localparam int OFS_SERIAL_DEFAULT = 1023;
  localparam int CLK_PERIOD_NS = 10;
  localparam int APB_AW = 8;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_LEVEL = 8'h04;
  localparam logic [7:0] ADDR_EMPTY_OFS = 8'h08;
  localparam logic [7:0] ADDR_FULL_OFS = 8'h0c;
  localparam int ST_FWFT = 0;
  localparam int ST_SERIAL = 1;
  localparam int ST_VALID = 2;
  localparam int ST_TIE = 3;
  localparam int ST_EMPTY = 4;
  localparam int ST_FULL = 5;
  localparam int ST_REPLAY = 6;

  typedef struct packed {
    logic wclk;
    logic rclk;
    logic wr_en_n;
    logic rd_en_n;
    logic serial_load_n;
    logic offset_access_n;
    logic full_reset_n;
    logic partial_reset_n;
    logic replay_n;
    logic mode_serial_in;
    logic tie_off_pin;
    logic out_en_n;
    logic [DATA_W-1:0] wr_data;
  } pin_in_t;

  // clocks low, strobes and resets inactive, outputs disabled
  localparam pin_in_t PIN_IDLE = 30'h0fe4_0000;

  typedef struct packed {
    logic full_or_space_avail;
    logic empty_or_word_valid;
    logic near_full_n;
    logic near_empty_n;
    logic half_level_n;
  } flags_t;

  // standard mode, empty buffer
  localparam flags_t FLAGS_RESET = 5'h15;
endpackage

/* File: deep_dual_clock_fifo.sv */
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - write and read data buses are 18 bits wide
// - write strobe on write clock rise stores a word or a parallel offset
// - serial load strobe on write clock rise shifts one offset bit in
// - read strobe on read clock rise presents next word or an offset
// - full reset clears both pointers and the output register
// - full reset captures timing mode, default offset and programming method
// - partial reset keeps mode, method and offsets
// - partial reset clears both pointers and the output register
// - retransmit on read clock rise rewinds only the read pointer
// - retransmit briefly forces empty low, or word valid high in fall-through
// - shared pin picks mode during full reset, then is serial data
// - offset pin during full reset picks default offset and method
// - after full reset, offset pin steers accesses to offset registers
// - standard mode: full/space output is a full flag
// - fall-through mode: full/space output signals room for a write
// - standard mode: empty/valid output is an empty flag
// - fall-through mode: empty/valid output signals a word on the outputs
// - near-full goes low when count exceeds depth minus full offset
// - near-empty goes low when count is below empty offset
// - half-level output shows more or less than half full
// - output enable pin decides whether read data is driven
// - fall-through: first word appears within three read clock transitions
// - offset pin low: 127 with parallel; high: 1023 with serial
// - retransmit pin is active low at a read clock rise
module deep_dual_clock_fifo #(
  parameter int DEPTH = dcfifo_pkg::DEPTH_DEFAULT // word depth, power of two
) (
  input wire logic pclk, // system clock, 100 MHz
  input wire logic presetn, // asynchronous reset, active low
  input wire logic [dcfifo_pkg::APB_AW-1:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire dcfifo_pkg::pin_in_t pins, // asynchronous producer and consumer pins
  output logic [dcfifo_pkg::DATA_W-1:0] rd_data, // read data
  output logic rd_data_oe, // high while read data is driven
  output dcfifo_pkg::flags_t flags // status flag pins
);
  localparam int ADDR_W = $clog2(DEPTH);
  localparam int CNT_W = ADDR_W + 1;
  localparam int OFS_W = ADDR_W;
  localparam int DW = dcfifo_pkg::DATA_W;

  dcfifo_pkg::pin_in_t pin_meta_reg;
  dcfifo_pkg::pin_in_t pin_sync_reg;
  logic wclk_prev_reg;
  logic rclk_prev_reg;
  logic [CNT_W-1:0] wr_ptr_reg;
  logic [CNT_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] wr_ptr_rside_reg;
  logic [CNT_W-1:0] rd_ptr_wside_reg;
  logic [DW-1:0] mem [DEPTH];
  logic fwft_mode_reg;
  logic serial_method_reg;
  logic [OFS_W-1:0] empty_ofs_reg;
  logic [OFS_W-1:0] full_ofs_reg;
  logic ofs_wr_idx_reg;
  logic ofs_rd_idx_reg;
  logic out_valid_reg;
  logic replay_hold_reg;
  dcfifo_pkg::flags_t flags_next;

  // every pin passes two flops; edges are found on the second stage only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_reg <= dcfifo_pkg::PIN_IDLE;
      pin_sync_reg <= dcfifo_pkg::PIN_IDLE;
      wclk_prev_reg <= 1'b0;
      rclk_prev_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= pins;
      pin_sync_reg <= pin_meta_reg;
      wclk_prev_reg <= pin_sync_reg.wclk;
      rclk_prev_reg <= pin_sync_reg.rclk;
    end
  end

  wire wclk_rise = pin_sync_reg.wclk & ~wclk_prev_reg;
  wire wclk_fall = ~pin_sync_reg.wclk & wclk_prev_reg;
  wire rclk_rise = pin_sync_reg.rclk & ~rclk_prev_reg;
  wire rclk_fall = ~pin_sync_reg.rclk & rclk_prev_reg;
  wire full_rst = ~pin_sync_reg.full_reset_n;
  wire part_rst = ~pin_sync_reg.partial_reset_n;
  wire ptr_clear = full_rst | part_rst;
  wire ofs_sel = ~pin_sync_reg.offset_access_n;

  // write side counts against its own copy of the read pointer, read side likewise
  wire [CNT_W-1:0] wcount = wr_ptr_reg - rd_ptr_wside_reg;
  wire [CNT_W-1:0] rcount = wr_ptr_rside_reg - rd_ptr_reg;
  wire mem_full = (wcount == CNT_W'(DEPTH));
  wire mem_empty = (rcount == '0);

  wire wr_strobe = wclk_rise & ~pin_sync_reg.wr_en_n & ~ptr_clear;
  wire word_wr = wr_strobe & ~ofs_sel & ~mem_full;
  wire par_ofs_wr = wr_strobe & ofs_sel & ~serial_method_reg;
  wire ser_ofs_wr = wclk_rise & ~pin_sync_reg.serial_load_n & ofs_sel & serial_method_reg & ~ptr_clear;
  wire rd_strobe = rclk_rise & ~pin_sync_reg.rd_en_n & ~ptr_clear;
  wire replay = rclk_rise & ~pin_sync_reg.replay_n & ~ptr_clear;
  wire ofs_rd = rd_strobe & ofs_sel;
  wire pop_ok = rclk_rise & ~ptr_clear & ~ofs_sel & ~mem_empty & ~replay & ~replay_hold_reg;
  wire std_pop = pop_ok & ~fwft_mode_reg & ~pin_sync_reg.rd_en_n;
  wire fwft_pop = pop_ok & fwft_mode_reg & (~out_valid_reg | ~pin_sync_reg.rd_en_n);
  wire pop = std_pop | fwft_pop;
  wire fwft_drain = rd_strobe & ~ofs_sel & fwft_mode_reg & ~fwft_pop;
  wire [DW-1:0] mem_q = mem[rd_ptr_reg[ADDR_W-1:0]];
  wire [OFS_W-1:0] ofs_rd_sel = ofs_rd_idx_reg ? full_ofs_reg : empty_ofs_reg;
  wire [OFS_W-1:0] ofs_default = pin_sync_reg.offset_access_n ?
                                 OFS_W'(dcfifo_pkg::OFS_SERIAL_DEFAULT) :
                                 OFS_W'(dcfifo_pkg::OFS_PARALLEL_DEFAULT);

  // apb decode
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pwrite & pready;
  wire hit_status = (paddr == dcfifo_pkg::ADDR_STATUS);
  wire hit_level = (paddr == dcfifo_pkg::ADDR_LEVEL);
  wire hit_eofs = (paddr == dcfifo_pkg::ADDR_EMPTY_OFS);
  wire hit_fofs = (paddr == dcfifo_pkg::ADDR_FULL_OFS);
  wire hit_any = hit_status | hit_level | hit_eofs | hit_fofs;
  wire apb_wr_eofs = apb_wr & hit_eofs;
  wire apb_wr_fofs = apb_wr & hit_fofs;
  wire [31:0] status_word = (32'(fwft_mode_reg) << dcfifo_pkg::ST_FWFT)
                          | (32'(serial_method_reg) << dcfifo_pkg::ST_SERIAL)
                          | (32'(out_valid_reg) << dcfifo_pkg::ST_VALID)
                          | (32'(pin_sync_reg.tie_off_pin) << dcfifo_pkg::ST_TIE)
                          | (32'(mem_empty) << dcfifo_pkg::ST_EMPTY)
                          | (32'(mem_full) << dcfifo_pkg::ST_FULL)
                          | (32'(replay_hold_reg) << dcfifo_pkg::ST_REPLAY);
  wire [31:0] rdata_mux = hit_status ? status_word :
                          hit_level ? 32'(rcount) :
                          hit_eofs ? 32'(empty_ofs_reg) :
                          hit_fofs ? 32'(full_ofs_reg) : 32'h0000_0000;

  // zero wait states: data and error are prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~hit_any;
      if (apb_setup)
        prdata <= rdata_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      wr_ptr_rside_reg <= '0;
      rd_ptr_wside_reg <= '0;
    end
    else if (ptr_clear)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      wr_ptr_rside_reg <= '0;
      rd_ptr_wside_reg <= '0;
    end
    else
    begin
      if (word_wr)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (replay)
        rd_ptr_reg <= {wr_ptr_rside_reg[ADDR_W], {ADDR_W{1'b0}}};
      else if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      // pointer copies move on the far clock's falling edge, away from its active edge
      if (rclk_fall)
        wr_ptr_rside_reg <= wr_ptr_reg;
      if (wclk_fall)
        rd_ptr_wside_reg <= rd_ptr_reg;
    end
  end

  // storage has no reset; a large array with one would not map to ram
  always_ff @(posedge pclk)
  begin
    if (word_wr)
      mem[wr_ptr_reg[ADDR_W-1:0]] <= pin_sync_reg.wr_data;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fwft_mode_reg <= 1'b0;
      serial_method_reg <= 1'b0;
    end
    else if (full_rst)
    begin
      fwft_mode_reg <= pin_sync_reg.mode_serial_in;
      serial_method_reg <= pin_sync_reg.offset_access_n;
    end
  end

  // partial reset does not reach this block, so settings survive it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      empty_ofs_reg <= OFS_W'(dcfifo_pkg::OFS_PARALLEL_DEFAULT);
      full_ofs_reg <= OFS_W'(dcfifo_pkg::OFS_PARALLEL_DEFAULT);
    end
    else if (full_rst)
    begin
      empty_ofs_reg <= ofs_default;
      full_ofs_reg <= ofs_default;
    end
    else if (apb_wr_eofs)
      empty_ofs_reg <= pwdata[OFS_W-1:0];
    else if (apb_wr_fofs)
      full_ofs_reg <= pwdata[OFS_W-1:0];
    else if (par_ofs_wr & ~ofs_wr_idx_reg)
      empty_ofs_reg <= pin_sync_reg.wr_data[OFS_W-1:0];
    else if (par_ofs_wr)
      full_ofs_reg <= pin_sync_reg.wr_data[OFS_W-1:0];
    else if (ser_ofs_wr)
      {full_ofs_reg, empty_ofs_reg} <= {pin_sync_reg.mode_serial_in, full_ofs_reg, empty_ofs_reg[OFS_W-1:1]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ofs_wr_idx_reg <= 1'b0;
      ofs_rd_idx_reg <= 1'b0;
    end
    else if (ptr_clear)
    begin
      ofs_wr_idx_reg <= 1'b0;
      ofs_rd_idx_reg <= 1'b0;
    end
    else
    begin
      if (par_ofs_wr)
        ofs_wr_idx_reg <= ~ofs_wr_idx_reg;
      if (ofs_rd)
        ofs_rd_idx_reg <= ~ofs_rd_idx_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_data <= '0;
      out_valid_reg <= 1'b0;
      replay_hold_reg <= 1'b0;
    end
    else if (ptr_clear)
    begin
      rd_data <= '0;
      out_valid_reg <= 1'b0;
      replay_hold_reg <= 1'b0;
    end
    else
    begin
      if (pop)
        rd_data <= mem_q;
      else if (ofs_rd)
        rd_data <= DW'(ofs_rd_sel);
      if (replay)
        out_valid_reg <= 1'b0;
      else if (fwft_pop)
        out_valid_reg <= 1'b1;
      else if (fwft_drain)
        out_valid_reg <= 1'b0;
      // the forced flag lasts until the next read clock rise
      if (replay)
        replay_hold_reg <= 1'b1;
      else if (rclk_rise)
        replay_hold_reg <= 1'b0;
    end
  end

  always_comb
  begin
    flags_next.full_or_space_avail = fwft_mode_reg ? mem_full : ~mem_full;
    flags_next.empty_or_word_valid = fwft_mode_reg ? ~(out_valid_reg & ~replay_hold_reg)
                                                   : ~(mem_empty | replay_hold_reg);
    flags_next.near_full_n = ~(wcount > (CNT_W'(DEPTH) - {1'b0, full_ofs_reg}));
    flags_next.near_empty_n = ~(rcount < {1'b0, empty_ofs_reg});
    flags_next.half_level_n = ~(wcount > CNT_W'(DEPTH / 2));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags <= dcfifo_pkg::FLAGS_RESET;
      rd_data_oe <= 1'b0;
    end
    else
    begin
      flags <= flags_next;
      rd_data_oe <= ~pin_sync_reg.out_en_n;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_full_reset;
    full_rst |=> (wr_ptr_reg == '0) && (rd_ptr_reg == '0) && (rd_data == '0);
  endproperty
  a_full_reset: assert property (p_full_reset) else $error("full reset left pointers or output set");

  property p_partial_keeps;
    part_rst && !full_rst |=> $stable(fwft_mode_reg) && $stable(serial_method_reg) && $stable(empty_ofs_reg)
                              && (rd_ptr_reg == '0) && (rd_data == '0);
  endproperty
  a_partial_keeps: assert property (p_partial_keeps) else $error("partial reset disturbed settings");

  property p_mode_latch;
    full_rst |=> (fwft_mode_reg == $past(pin_sync_reg.mode_serial_in))
                 && (serial_method_reg == $past(pin_sync_reg.offset_access_n));
  endproperty
  a_mode_latch: assert property (p_mode_latch) else $error("mode or method not captured");

  property p_replay_rewind;
    replay |=> (rd_ptr_reg[ADDR_W-1:0] == '0) && (wr_ptr_reg == $past(wr_ptr_reg) + CNT_W'($past(word_wr)));
  endproperty
  a_replay_rewind: assert property (p_replay_rewind) else $error("retransmit did not rewind read side only");

  property p_replay_flag;
    replay && !fwft_mode_reg |-> ##2 !flags.empty_or_word_valid;
  endproperty
  a_replay_flag: assert property (p_replay_flag) else $error("empty not forced on retransmit");

  property p_word_write;
    word_wr |=> (wr_ptr_reg == $past(wr_ptr_reg) + 1'b1);
  endproperty
  a_word_write: assert property (p_word_write) else $error("write pointer did not advance");

  property p_serial_shift;
    ser_ofs_wr && !apb_wr |=> (empty_ofs_reg[OFS_W-1] == $past(full_ofs_reg[0]))
                             && (full_ofs_reg[OFS_W-1] == $past(pin_sync_reg.mode_serial_in));
  endproperty
  a_serial_shift: assert property (p_serial_shift) else $error("serial bit not shifted");

  property p_full_flag;
    !fwft_mode_reg && mem_full |=> !flags.full_or_space_avail;
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag not low at full");

  property p_empty_flag;
    !fwft_mode_reg && !mem_empty && !replay_hold_reg |=> flags.empty_or_word_valid;
  endproperty
  a_empty_flag: assert property (p_empty_flag) else $error("empty flag low with data");

  property p_fall_through;
    fwft_pop |=> out_valid_reg ##1 !flags.empty_or_word_valid;
  endproperty
  a_fall_through: assert property (p_fall_through) else $error("word did not fall through");

  property p_output_enable;
    pin_sync_reg.out_en_n |=> !rd_data_oe;
  endproperty
  a_output_enable: assert property (p_output_enable) else $error("data driven while disabled");
endmodule

/* File: far_end.sv */
`timescale 1ns/1ps
module far_end (
  input wire logic pclk, // system clock
  input wire logic [dcfifo_pkg::DATA_W-1:0] rd_data, // word seen by the consumer
  output dcfifo_pkg::pin_in_t pins // producer and consumer pins
);
  logic [2:0] ph_reg = 3'h0;
  initial
  begin
    pins = dcfifo_pkg::PIN_IDLE;
  end
  // both link clocks run at 80 ns, the read clock a quarter period ahead
  always @(posedge pclk)
  begin
    ph_reg <= ph_reg + 3'h1;
    pins.wclk <= ph_reg[2];
    pins.rclk <= ph_reg[2] ^ ph_reg[1];
  end
  // strobes move on the falling link edge so they stand steady around the rise
  task automatic push(input logic [17:0] d, input logic ofs, input int n);
    @(negedge pins.wclk);
    pins.offset_access_n <= ~ofs;
    pins.wr_en_n <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      pins.wr_data <= d + 18'(i);
      @(negedge pins.wclk);
    end
    pins.wr_en_n <= 1'b1;
    pins.offset_access_n <= 1'b1;
    pins.wr_data <= ~pins.wr_data;
  endtask
  task automatic pop(input logic ofs, output logic [17:0] q);
    @(negedge pins.rclk);
    pins.offset_access_n <= ~ofs;
    pins.rd_en_n <= 1'b0;
    @(negedge pins.rclk);
    pins.rd_en_n <= 1'b1;
    pins.offset_access_n <= 1'b1;
    repeat (2) @(posedge pclk);
    q = rd_data;
  endtask
  // serial loading only reaches the offsets while the offset pin is held low with the serial strobe
  task automatic shift_bits(input logic [19:0] b);
    @(negedge pins.wclk);
    pins.offset_access_n <= 1'b0;
    pins.serial_load_n <= 1'b0;
    for (int i = 0; i < 20; i++)
    begin
      pins.mode_serial_in <= b[i];
      @(negedge pins.wclk);
    end
    pins.serial_load_n <= 1'b1;
    pins.offset_access_n <= 1'b1;
    pins.mode_serial_in <= ~b[19];
  endtask
  task automatic replay();
    @(negedge pins.rclk);
    pins.replay_n <= 1'b0;
    @(negedge pins.rclk);
    pins.replay_n <= 1'b1;
  endtask
  // mode and method are latched from shared pins, so they are held past release
  task automatic link_reset(input logic full, input logic fwft, input logic ser);
    @(posedge pclk);
    pins.mode_serial_in <= fwft;
    pins.offset_access_n <= ser;
    pins.full_reset_n <= ~full;
    pins.partial_reset_n <= full;
    repeat (20) @(posedge pclk);
    pins.full_reset_n <= 1'b1;
    pins.partial_reset_n <= 1'b1;
    repeat (10) @(posedge pclk);
    pins.offset_access_n <= 1'b1;
    repeat (10) @(posedge pclk);
  endtask
  task automatic out_enable(input logic en);
    @(posedge pclk);
    pins.out_en_n <= ~en;
  endtask
endmodule

/* File: deep_dual_clock_fifo_tb_top.sv */
`timescale 1ns/1ps
module deep_dual_clock_fifo_tb_top;
  localparam int DEPTH = 1024;
  typedef struct packed {
    logic [10:0] cnt;
    dcfifo_pkg::flags_t fl;
  } row_t;
  // levels on both sides of each threshold with the 127 default offsets
  row_t rows [8] = '{'{11'h001, 5'h1d}, '{11'h07e, 5'h1d}, '{11'h07f, 5'h1f}, '{11'h1ff, 5'h1f},
    '{11'h201, 5'h1e}, '{11'h381, 5'h1e}, '{11'h382, 5'h1a}, '{11'h400, 5'h0a}};
  logic pclk, pready, pslverr, rd_data_oe, err;
  logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [17:0] rd_data, q;
  dcfifo_pkg::pin_in_t pins;
  dcfifo_pkg::flags_t flags;
  int bad_count, total_checks, cyc, wc;
  deep_dual_clock_fifo #(.DEPTH(DEPTH)) deep_dual_clock_fifo_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .rd_data(rd_data), .rd_data_oe(rd_data_oe), .flags(flags));
  far_end far_end_i (.pclk(pclk), .rd_data(rd_data), .pins(pins));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      bad_count++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rv);
  endtask
  task automatic settle();
    repeat (40) @(posedge pclk);
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    chk("flags", 32'(dcfifo_pkg::FLAGS_RESET), 32'(flags));
    chk("oe", 32'h0, 32'(rd_data_oe));
    presetn <= 1'b1;
    far_end_i.link_reset(1'b1, 1'b0, 1'b0);
    rd_chk("status", dcfifo_pkg::ADDR_STATUS, 32'h10);
    rd_chk("empty_ofs", dcfifo_pkg::ADDR_EMPTY_OFS, 32'h7f);
    rd_chk("full_ofs", dcfifo_pkg::ADDR_FULL_OFS, 32'h7f);
    apb(1'b1, dcfifo_pkg::ADDR_STATUS, 32'hff);
    rd_chk("unmapped", 8'h10, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    rd_chk("status_ro", dcfifo_pkg::ADDR_STATUS, 32'h10);
    $display("test reset done");
    wc = 0;
    foreach (rows[r])
    begin
      far_end_i.push(18'h1_0000 + 18'(wc), 1'b0, int'(rows[r].cnt) - wc);
      wc = int'(rows[r].cnt);
      settle();
      chk("flags", 32'(rows[r].fl), 32'(flags));
      rd_chk("level", dcfifo_pkg::ADDR_LEVEL, 32'(rows[r].cnt));
    end
    far_end_i.push(18'h3_ffff, 1'b0, 1);
    settle();
    chk("full", 32'h0a, 32'(flags));
    for (int i = 0; i < DEPTH; i++)
    begin
      far_end_i.pop(1'b0, q);
      chk("word", 32'h0001_0000 + 32'(i), 32'(q));
    end
    far_end_i.pop(1'b0, q);
    settle();
    chk("empty", 32'(dcfifo_pkg::FLAGS_RESET), 32'(flags));
    chk("hold", 32'h0001_03ff, 32'(q));
    far_end_i.out_enable(1'b1);
    settle();
    chk("oe", 32'h1, 32'(rd_data_oe));
    far_end_i.out_enable(1'b0);
    settle();
    chk("oe", 32'h0, 32'(rd_data_oe));
    $display("test fill and drain done");
    far_end_i.push(18'h0_0005, 1'b1, 2);
    rd_chk("empty_ofs", dcfifo_pkg::ADDR_EMPTY_OFS, 32'h5);
    rd_chk("full_ofs", dcfifo_pkg::ADDR_FULL_OFS, 32'h6);
    far_end_i.pop(1'b1, q);
    chk("ofs_rd", 32'h5, 32'(q));
    far_end_i.pop(1'b1, q);
    chk("ofs_rd", 32'h6, 32'(q));
    far_end_i.push(18'h2_0000, 1'b0, 3);
    far_end_i.pop(1'b0, q);
    far_end_i.link_reset(1'b0, 1'b0, 1'b0);
    chk("rd_data", 32'h0, 32'(rd_data));
    rd_chk("level", dcfifo_pkg::ADDR_LEVEL, 32'h0);
    rd_chk("empty_ofs", dcfifo_pkg::ADDR_EMPTY_OFS, 32'h5);
    $display("test offsets and partial reset done");
    far_end_i.push(18'h3_0000, 1'b0, 4);
    far_end_i.pop(1'b0, q);
    far_end_i.pop(1'b0, q);
    far_end_i.replay();
    repeat (2) @(posedge pclk);
    chk("ef_replay", 32'h0, 32'(flags.empty_or_word_valid));
    settle();
    rd_chk("level", dcfifo_pkg::ADDR_LEVEL, 32'h4);
    far_end_i.pop(1'b0, q);
    chk("replay_word", 32'h0003_0000, 32'(q));
    $display("test retransmit done");
    far_end_i.link_reset(1'b1, 1'b1, 1'b1);
    chk("rd_data", 32'h0, 32'(rd_data));
    rd_chk("status", dcfifo_pkg::ADDR_STATUS, 32'h13);
    rd_chk("empty_ofs", dcfifo_pkg::ADDR_EMPTY_OFS, 32'h3ff);
    chk("or_idle", 32'h1, 32'(flags.empty_or_word_valid));
    far_end_i.push(18'h2_aaaa, 1'b0, 1);
    settle();
    chk("fwft_word", 32'h0002_aaaa, 32'(rd_data));
    chk("or_valid", 32'h0, 32'(flags.empty_or_word_valid));
    chk("ir_space", 32'h0, 32'(flags.full_or_space_avail));
    far_end_i.shift_bits({10'h009, 10'h005});
    rd_chk("empty_ofs", dcfifo_pkg::ADDR_EMPTY_OFS, 32'h5);
    rd_chk("full_ofs", dcfifo_pkg::ADDR_FULL_OFS, 32'h9);
    far_end_i.push(18'h1_5555, 1'b0, 1);
    settle();
    far_end_i.pop(1'b0, q);
    chk("fwft_next", 32'h0001_5555, 32'(q));
    chk("near_empty", 32'h0, 32'(flags.near_empty_n));
    apb(1'b1, dcfifo_pkg::ADDR_EMPTY_OFS, 32'h0000_0000);
    rd_chk("empty_ofs", dcfifo_pkg::ADDR_EMPTY_OFS, 32'h0);
    chk("near_empty", 32'h1, 32'(flags.near_empty_n));
    $display("test fall through done");
    complete_run();
  end
endmodule
